// ==== src/ap_bank_sequencer.sv ====
// Purpose: samples the command bus on the command clock and sequences bank precharge
// Assumes: command clock far slower than clock_in; pins pass two flip-flops
// Notes: a decoded command takes effect half a command clock after its rising edge
`timescale 1ns/1ps
// Function
// - read or write carries auto_close_flag on CA0 at the falling edge.
// - without auto_close_flag the burst runs and the bank stays open.
// - read auto close starts at max(BL/2, BL/2-4+RU(tRTP/tCK)) clocks.
// - write auto close starts tWR clocks after the write burst ends.
// - precharge all_bank_flag on CA4 rising, else bank on CA9 to CA7.
module ap_bank_sequencer #(
   parameter int unsigned BL = ap_seq_pkg::BURST_LEN,
   parameter int unsigned RL = ap_seq_pkg::READ_LAT,
   parameter int unsigned WL = ap_seq_pkg::WRITE_LAT,
   parameter int unsigned RTP = ap_seq_pkg::RTP_CK,
   parameter int unsigned WR = ap_seq_pkg::WR_CK,
   parameter int unsigned RPPB = ap_seq_pkg::RPPB_CK,
   parameter int unsigned RPAB = ap_seq_pkg::RPAB_CK,
   parameter int unsigned RC = ap_seq_pkg::RC_CK,
   parameter int unsigned DQSCK = ap_seq_pkg::DQSCK_CK,
   parameter int unsigned WTR = ap_seq_pkg::WTR_CK
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // command pins
   input wire logic ck_in,
   input wire logic cs_n_in,
   input wire logic [9:0] ca_in,
   // bank status
   output logic [ap_seq_pkg::NUM_BANKS-1:0] bank_open_out,
   output logic [ap_seq_pkg::NUM_BANKS-1:0] bank_precharging_out,
   output logic [ap_seq_pkg::NUM_BANKS-1:0] ap_start_out,
   // command checks
   output logic bank_error_out,
   output logic spacing_error_out
);
   localparam int unsigned HALF_BL = BL / 2;
   localparam int unsigned RD_PRE = HALF_BL + ((RTP > 4) ? RTP : 4) - 4;
   localparam int unsigned WR_PRE = WL + HALF_BL + WR + 1;
   localparam int unsigned RDAP_TO_WR = RL + HALF_BL + DQSCK + 1 - WL;
   localparam int unsigned WRAP_TO_RD = WL + HALF_BL + WTR + 1;
   localparam logic [7:0] ONE = 8'h01;

   // counters are 8 bits wide and the bank field is 3 bits
   if (ap_seq_pkg::CNT_W != 8 || ap_seq_pkg::NUM_BANKS != 8) begin : g_bad_width
      $error("counter or bank field width not supported");
   end
   if (BL < 8) begin : g_bad_bl
      $error("burst length below the prefetch size");
   end
   if (WL > RL + HALF_BL + DQSCK) begin : g_bad_lat
      $error("write latency makes the read to write gap negative");
   end
   if (RD_PRE > 255 || WR_PRE > 255 || RDAP_TO_WR > 255 || WRAP_TO_RD > 255) begin : g_bad_win
      $error("command window does not fit an 8-bit counter");
   end
   if (RC > 255 || RPPB > 255 || RPAB > 255) begin : g_bad_cnt
      $error("precharge or cycle count does not fit an 8-bit counter");
   end
   if (RPPB < 1 || RPAB < 1) begin : g_bad_rp
      $error("precharge period must span at least one command clock");
   end

   logic [2:0] ck_sync;
   logic cs_n_meta;
   logic cs_n_sync;
   logic [9:0] ca_meta;
   logic [9:0] ca_sync;
   logic ck_rise;
   logic ck_fall;
   logic [9:0] ca_rise;
   logic cs_sel;
   ap_seq_pkg::cmd_s cmd;
   logic [7:0] rd_gap;
   logic [7:0] wr_gap;
   logic [ap_seq_pkg::NUM_BANKS-1:0] bank_err;
   logic [ap_seq_pkg::NUM_BANKS-1:0] ap_pulse;
   logic op_pre;
   logic op_rd;
   logic op_wr;
   logic op_act;

   // pins cross into clock_in through two flops before anything reads them
   // ca is held for a whole half period, so one cycle of skew against ck is harmless
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ck_sync <= '0;
         cs_n_meta <= 1'b1;
         cs_n_sync <= 1'b1;
         ca_meta <= '0;
         ca_sync <= '0;
      end else begin
         ck_sync <= {ck_sync[1:0], ck_in};
         cs_n_meta <= cs_n_in;
         cs_n_sync <= cs_n_meta;
         ca_meta <= ca_in;
         ca_sync <= ca_meta;
      end
   end
   assign ck_rise = ck_sync[1] && !ck_sync[2];
   assign ck_fall = !ck_sync[1] && ck_sync[2];

   // rising half holds opcode and bank, falling half holds the auto close bit
   // a cut frame never reaches its falling half, so it decodes as nothing
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ca_rise <= '0;
         cs_sel <= 1'b0;
      end else if (ck_rise) begin
         ca_rise <= ca_sync;
         cs_sel <= !cs_n_sync;
      end else if (ck_fall) begin
         cs_sel <= 1'b0;
      end
   end

   // opcode match on the rising half; the patterns are disjoint
   assign op_pre = (ca_rise[3:0] & ap_seq_pkg::OP_PRE_MASK) == ap_seq_pkg::OP_PRE_VAL;
   assign op_rd = (ca_rise[3:0] & ap_seq_pkg::OP_RD_MASK) == ap_seq_pkg::OP_RD_VAL;
   assign op_wr = (ca_rise[3:0] & ap_seq_pkg::OP_WR_MASK) == ap_seq_pkg::OP_WR_VAL;
   assign op_act = (ca_rise[3:0] & ap_seq_pkg::OP_ACT_MASK) == ap_seq_pkg::OP_ACT_VAL;

   always_comb begin
      cmd.kind = ap_seq_pkg::CMD_NONE;
      cmd.bank = ca_rise[ap_seq_pkg::CA_BANK_MSB:ap_seq_pkg::CA_BANK_LSB];
      cmd.auto_close_flag = ca_sync[ap_seq_pkg::CA_AUTO_CLOSE_BIT];
      cmd.all_bank_flag = ca_rise[ap_seq_pkg::CA_ALL_BANK_BIT];
      if (ck_fall && cs_sel) begin
         if (op_pre) begin
            cmd.kind = ap_seq_pkg::CMD_PRE;
         end else if (op_rd) begin
            cmd.kind = ap_seq_pkg::CMD_RD;
         end else if (op_wr) begin
            cmd.kind = ap_seq_pkg::CMD_WR;
         end else if (op_act) begin
            cmd.kind = ap_seq_pkg::CMD_ACT;
         end
      end
   end

   // one timer per bank; precharge all fans out to every bank
   for (genvar b = 0; b < ap_seq_pkg::NUM_BANKS; b++) begin : g_bank
      ap_seq_pkg::bank_evt_s evt;
      ap_seq_pkg::bank_state_e st;
      logic hit;
      assign hit = cmd.bank == 3'(b);
      assign evt.act = cmd.kind == ap_seq_pkg::CMD_ACT && hit;
      assign evt.rd = cmd.kind == ap_seq_pkg::CMD_RD && hit;
      assign evt.wr = cmd.kind == ap_seq_pkg::CMD_WR && hit;
      assign evt.auto_close_flag = cmd.auto_close_flag;
      assign evt.pre = cmd.kind == ap_seq_pkg::CMD_PRE && (cmd.all_bank_flag || hit);
      assign evt.all_bank_flag = cmd.all_bank_flag;
      bank_timer #(
         .RD_AP_DLY(RD_PRE),
         .WR_AP_DLY(WR_PRE),
         .RD_PRE_WIN(RD_PRE),
         .WR_PRE_WIN(WR_PRE),
         .RPPB(RPPB),
         .RPAB(RPAB),
         .RC(RC)
      ) u_bank (
         .clock_in(clock_in),
         .rst_in(rst_in),
         .tick_in(ck_rise),
         .evt_in(evt),
         .state_out(st),
         .ap_start_out(ap_pulse[b]),
         .error_out(bank_err[b])
      );
      assign bank_open_out[b] = st == ap_seq_pkg::BANK_ACTIVE || st == ap_seq_pkg::BANK_AP_WAIT;
      assign bank_precharging_out[b] = st == ap_seq_pkg::BANK_PRECHARGING;
   end
   assign ap_start_out = ap_pulse;
   assign bank_error_out = |bank_err;

   // cross-bank gaps after auto close bursts; same-bank access is a bank error
   // overlapping bursts keep only the longer remaining window
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rd_gap <= '0;
         wr_gap <= '0;
      end else if (cmd.kind == ap_seq_pkg::CMD_RD && cmd.auto_close_flag) begin
         rd_gap <= (rd_gap > HALF_BL[7:0]) ? rd_gap : HALF_BL[7:0];
         wr_gap <= (wr_gap > RDAP_TO_WR[7:0]) ? wr_gap : RDAP_TO_WR[7:0];
      end else if (cmd.kind == ap_seq_pkg::CMD_WR && cmd.auto_close_flag) begin
         rd_gap <= (rd_gap > WRAP_TO_RD[7:0]) ? rd_gap : WRAP_TO_RD[7:0];
         wr_gap <= (wr_gap > HALF_BL[7:0]) ? wr_gap : HALF_BL[7:0];
      end else if (ck_rise) begin
         rd_gap <= (rd_gap != '0) ? rd_gap - ONE : rd_gap;
         wr_gap <= (wr_gap != '0) ? wr_gap - ONE : wr_gap;
      end
   end

   // precharge to precharge is one clock, met by any two commands
   // a running auto close burst is never cut short by this block
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         spacing_error_out <= 1'b0;
      end else begin
         spacing_error_out <= (cmd.kind == ap_seq_pkg::CMD_RD && rd_gap != '0) ||
                              (cmd.kind == ap_seq_pkg::CMD_WR && wr_gap != '0);
      end
   end
endmodule

// ==== src/ap_seq_pkg.sv ====
// Purpose: shared constants and types for the bank precharge sequencer
// Assumes: all delays count rising edges of the command clock
// Notes: command encodings cover only the commands that this block tracks
package ap_seq_pkg;
   localparam int unsigned NUM_BANKS = 8;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned BURST_LEN = 8;
   localparam int unsigned READ_LAT = 6;
   localparam int unsigned WRITE_LAT = 4;
   // times in ns, plain defaults
   localparam int unsigned T_CK_NS = 160;
   localparam int unsigned T_RTP_NS = 8;
   localparam int unsigned T_WR_NS = 15;
   localparam int unsigned T_RPPB_NS = 18;
   localparam int unsigned T_RPAB_NS = 21;
   localparam int unsigned T_RC_NS = 60;
   localparam int unsigned T_DQSCK_MAX_NS = 6;
   localparam int unsigned T_WTR_NS = 8;
   // round-up counts in command clocks
   localparam int unsigned RTP_CK = (T_RTP_NS + T_CK_NS - 1) / T_CK_NS;
   localparam int unsigned WR_CK = (T_WR_NS + T_CK_NS - 1) / T_CK_NS;
   localparam int unsigned RPPB_CK = (T_RPPB_NS + T_CK_NS - 1) / T_CK_NS;
   localparam int unsigned RPAB_CK = (T_RPAB_NS + T_CK_NS - 1) / T_CK_NS;
   localparam int unsigned RC_CK = (T_RC_NS + T_CK_NS - 1) / T_CK_NS;
   localparam int unsigned DQSCK_CK = (T_DQSCK_MAX_NS + T_CK_NS - 1) / T_CK_NS;
   localparam int unsigned WTR_CK = (T_WTR_NS + T_CK_NS - 1) / T_CK_NS;
   // command/address bit positions
   localparam int unsigned CA_AUTO_CLOSE_BIT = 0;
   localparam int unsigned CA_ALL_BANK_BIT = 4;
   localparam int unsigned CA_BANK_LSB = 7;
   localparam int unsigned CA_BANK_MSB = 9;
   // rising-edge opcode patterns on ca[3:0] and their care masks
   localparam logic [3:0] OP_ACT_MASK = 4'h3;
   localparam logic [3:0] OP_ACT_VAL = 4'h2;
   localparam logic [3:0] OP_WR_MASK = 4'h7;
   localparam logic [3:0] OP_WR_VAL = 4'h1;
   localparam logic [3:0] OP_RD_MASK = 4'h7;
   localparam logic [3:0] OP_RD_VAL = 4'h5;
   localparam logic [3:0] OP_PRE_MASK = 4'hf;
   localparam logic [3:0] OP_PRE_VAL = 4'hb;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_ACT = 3'h1,
      CMD_RD = 3'h2,
      CMD_WR = 3'h3,
      CMD_PRE = 3'h4
   } cmd_e;

   typedef struct packed {
      cmd_e kind;
      logic [2:0] bank;
      logic auto_close_flag;
      logic all_bank_flag;
   } cmd_s;

   // bank states, gray along idle, active, auto wait, precharging
   typedef enum logic [1:0] {
      BANK_IDLE = 2'h0,
      BANK_ACTIVE = 2'h1,
      BANK_AP_WAIT = 2'h3,
      BANK_PRECHARGING = 2'h2
   } bank_state_e;

   typedef struct packed {
      logic act;
      logic rd;
      logic wr;
      logic auto_close_flag;
      logic pre;
      logic all_bank_flag;
   } bank_evt_s;
endpackage

// ==== src/bank_timer.sv ====
// Purpose: one bank's state and its precharge, tRP and tRC counters
// Assumes: events arrive on falling-edge decode, ticks on rising edges
// Notes: events and ticks never share a cycle
`timescale 1ns/1ps
module bank_timer #(
   parameter int unsigned RD_AP_DLY = 4,
   parameter int unsigned WR_AP_DLY = 10,
   parameter int unsigned RD_PRE_WIN = 4,
   parameter int unsigned WR_PRE_WIN = 10,
   parameter int unsigned RPPB = 1,
   parameter int unsigned RPAB = 1,
   parameter int unsigned RC = 1
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // timing and commands
   input wire logic tick_in,
   input wire ap_seq_pkg::bank_evt_s evt_in,
   // status
   output ap_seq_pkg::bank_state_e state_out,
   output logic ap_start_out,
   output logic error_out
);
   localparam logic [ap_seq_pkg::CNT_W-1:0] ONE = 8'h01;
   ap_seq_pkg::bank_state_e state;
   logic [ap_seq_pkg::CNT_W-1:0] ap_cnt;
   logic [ap_seq_pkg::CNT_W-1:0] rp_cnt;
   logic [ap_seq_pkg::CNT_W-1:0] rc_cnt;
   logic [ap_seq_pkg::CNT_W-1:0] pre_win;
   logic [ap_seq_pkg::CNT_W-1:0] next_win;
   logic ap_fire;

   assign state_out = state;
   assign ap_fire = tick_in && state == ap_seq_pkg::BANK_AP_WAIT && ap_cnt == ONE;
   always_comb begin
      next_win = pre_win;
      if (evt_in.rd && pre_win < RD_PRE_WIN[7:0]) begin
         next_win = RD_PRE_WIN[7:0];
      end else if (evt_in.wr && pre_win < WR_PRE_WIN[7:0]) begin
         next_win = WR_PRE_WIN[7:0];
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state <= ap_seq_pkg::BANK_IDLE;
         ap_cnt <= '0;
      end else begin
         case (state)
            ap_seq_pkg::BANK_IDLE: begin
               if (evt_in.act) begin
                  state <= ap_seq_pkg::BANK_ACTIVE;
               end else if (evt_in.pre) begin
                  state <= ap_seq_pkg::BANK_PRECHARGING;
               end
            end
            ap_seq_pkg::BANK_ACTIVE: begin
               if ((evt_in.rd || evt_in.wr) && evt_in.auto_close_flag) begin
                  state <= ap_seq_pkg::BANK_AP_WAIT;
                  ap_cnt <= evt_in.rd ? RD_AP_DLY[7:0] : WR_AP_DLY[7:0];
               end else if (evt_in.pre) begin
                  state <= ap_seq_pkg::BANK_PRECHARGING;
               end
               // plain read or write keeps the row open
            end
            ap_seq_pkg::BANK_AP_WAIT: begin
               if (tick_in) begin
                  ap_cnt <= ap_cnt - ONE;
                  if (ap_cnt == ONE) begin
                     state <= ap_seq_pkg::BANK_PRECHARGING;
                  end
               end
            end
            ap_seq_pkg::BANK_PRECHARGING: begin
               if (evt_in.act && rp_cnt == '0) begin
                  state <= ap_seq_pkg::BANK_ACTIVE;
               end else if (tick_in && rp_cnt == ONE) begin
                  state <= ap_seq_pkg::BANK_IDLE;
               end
            end
            default: state <= ap_seq_pkg::BANK_IDLE;
         endcase
      end
   end

   // precharge period restarts from the latest precharge that covered the bank, except one that arrives during the auto close wait
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rp_cnt <= '0;
      end else if (ap_fire) begin
         rp_cnt <= RPPB[7:0];
      end else if (evt_in.pre && state != ap_seq_pkg::BANK_AP_WAIT) begin
         rp_cnt <= evt_in.all_bank_flag ? RPAB[7:0] : RPPB[7:0];
      end else if (tick_in && rp_cnt != '0) begin
         rp_cnt <= rp_cnt - ONE;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rc_cnt <= '0;
      end else if (evt_in.act) begin
         rc_cnt <= RC[7:0];
      end else if (tick_in && rc_cnt != '0) begin
         rc_cnt <= rc_cnt - ONE;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         pre_win <= '0;
      end else if (evt_in.rd || evt_in.wr) begin
         pre_win <= next_win;
      end else if (tick_in && pre_win != '0) begin
         pre_win <= pre_win - ONE;
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ap_start_out <= 1'b0;
         error_out <= 1'b0;
      end else begin
         ap_start_out <= ap_fire;
         // activate needs idle bank with tRP and tRC both spent
         // read or write needs an open bank with no auto close pending
         // precharge inside the read or write window
         error_out <= (evt_in.act && (state == ap_seq_pkg::BANK_ACTIVE ||
                       state == ap_seq_pkg::BANK_AP_WAIT || rp_cnt != '0 || rc_cnt != '0)) ||
                      ((evt_in.rd || evt_in.wr) && state != ap_seq_pkg::BANK_ACTIVE) ||
                      (evt_in.pre && pre_win != '0);
      end
   end
endmodule

// ==== test/ap_bank_sequencer_tb_top.sv ====
// Purpose: self-checking bench for the bank precharge sequencer
// Assumes: bank pairs and spare pin bits drawn from a fixed seed
// Notes: each window is probed at its minimum and one frame short
`timescale 1ns/1ps
module ap_bank_sequencer_tb_top;
   localparam int BH = ap_seq_pkg::BURST_LEN / 2;
   localparam int RTP = ap_seq_pkg::RTP_CK;
   localparam int RD_PRE = BH + ((RTP > 4) ? RTP : 4) - 4;
   localparam int WR_PRE = ap_seq_pkg::WRITE_LAT + BH + ap_seq_pkg::WR_CK + 1;
   localparam int RD_WR = ap_seq_pkg::READ_LAT + BH + ap_seq_pkg::DQSCK_CK -
      ap_seq_pkg::WRITE_LAT + 1;
   localparam int WR_RD = ap_seq_pkg::WRITE_LAT + BH + ap_seq_pkg::WTR_CK + 1;
   localparam int PB = ap_seq_pkg::RPPB_CK;
   localparam ap_seq_pkg::cmd_e NOP = ap_seq_pkg::CMD_NONE;
   localparam ap_seq_pkg::cmd_e ACT = ap_seq_pkg::CMD_ACT;
   localparam ap_seq_pkg::cmd_e RD = ap_seq_pkg::CMD_RD;
   localparam ap_seq_pkg::cmd_e WR = ap_seq_pkg::CMD_WR;
   localparam ap_seq_pkg::cmd_e PRE = ap_seq_pkg::CMD_PRE;
   logic clock_in, rst_in, ck, cs_n, go, busy, err_b, err_s;
   logic [9:0] ca, fill;
   logic [7:0] open_b, pre_b, ap_b;
   ap_seq_pkg::cmd_s cmd;
   logic [31:0] seed = 32'h9b24_9064;
   logic [15:0] fcnt, ap_frame;
   logic [2:0] ba, bb;
   int mismatches, num_checks, nb, ns;
   ap_bank_sequencer dut (.clock_in(clock_in), .rst_in(rst_in), .ck_in(ck), .cs_n_in(cs_n),
      .ca_in(ca), .bank_open_out(open_b), .bank_precharging_out(pre_b), .ap_start_out(ap_b),
      .bank_error_out(err_b), .spacing_error_out(err_s));
   ap_ctrl_model u_ctrl (.clock_in(clock_in), .go_in(go), .cmd_in(cmd), .fill_in(fill),
      .ck_out(ck), .cs_n_out(cs_n), .ca_out(ca), .busy_out(busy));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic int ap_dly(input ap_seq_pkg::cmd_e k);
      int r;
      r = BH - 4 + RTP;
      if (r < BH) begin
         r = BH;
      end
      return (k == RD) ? r : WR_PRE;
   endfunction
   // error pulses last one cycle, so counting them is enough
   always @(posedge clock_in) begin
      if (ap_b[ba] === 1'b1) ap_frame <= fcnt;
      if (err_b === 1'b1) nb <= nb + 1;
      if (err_s === 1'b1) ns <= ns + 1;
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic send(input ap_seq_pkg::cmd_e k, input logic [2:0] b, input logic ap,
      input logic ab);
      int w;
      fill <= seed[9:0];
      seed = xs(seed);
      fcnt <= fcnt + 16'h0001;
      cmd <= '{k, b, ap, ab};
      go <= 1'b1;
      for (w = 0; w < 40 && busy !== 1'b1; w++) @(posedge clock_in);
      cmp(16'(busy), 16'h0001);
      go <= 1'b0;
      for (w = 0; w < 40 && busy !== 1'b0; w++) @(posedge clock_in);
      cmp(16'(busy), 16'h0000);
   endtask
   task automatic nop(input int n);
      repeat (n) send(NOP, 3'h0, 1'b0, 1'b0);
   endtask
   task automatic run(input ap_seq_pkg::cmd_e k1, input logic ap1, input ap_seq_pkg::cmd_e k2,
      input logic ab2, input logic same, input int gap, input logic eb, input logic es);
      int b0, s0;
      logic [15:0] n;
      ba = seed[2:0];
      bb = ba + 3'h1 + (seed[5:3] % 3'h7);
      b0 = nb;
      s0 = ns;
      ap_frame = 16'h0000;
      send(ACT, ba, 1'b0, 1'b0);
      send(ACT, bb, 1'b0, 1'b0);
      send(k1, ba, ap1, 1'b0);
      n = fcnt;
      nop(gap - 1);
      send(k2, same ? ba : bb, 1'b0, ab2);
      nop(14);
      cmp(16'(nb != b0), 16'(eb));
      cmp(16'(ns != s0), 16'(es));
      if (!same) begin
         cmp(ap_frame, ap1 ? 16'(n + ap_dly(k1)) : 16'h0000);
         cmp(16'(open_b[ba]), 16'(k1 != PRE && !ap1 && !ab2));
      end
      cmp(16'(open_b[bb]), 16'(!(k2 == PRE && ab2)));
      send(PRE, 3'h0, 1'b0, 1'b1);
      nop(4);
      cmp({8'h00, open_b}, 16'h0000);
      $display("test done at %0t", $time);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // about 18.8k cycles expected; a generous margin before giving up
   initial begin
      #600_000;
      mismatches++;
      $display("Error at %0t: watchdog expired", $time);
      wrap_up();
   end
   initial begin
      {rst_in, go, cmd, fill, fcnt, ap_frame} = '0;
      rst_in = 1'b1;
      {mismatches, num_checks, nb, ns} = '0;
      repeat (8) @(negedge clock_in);
      rst_in = 1'b0;
      repeat (6) @(posedge clock_in);
      cmp({open_b, pre_b | ap_b}, 16'h0000);
      repeat (2) begin
         run(RD, 1, RD, 0, 0, BH, 0, 0);
         run(RD, 1, RD, 0, 0, BH - 1, 0, 1);
         run(RD, 1, WR, 0, 0, RD_WR, 0, 0);
         run(RD, 1, WR, 0, 0, RD_WR - 1, 0, 1);
         run(WR, 1, RD, 0, 0, WR_RD, 0, 0);
         run(WR, 1, RD, 0, 0, WR_RD - 1, 0, 1);
         run(WR, 1, WR, 0, 0, BH, 0, 0);
         run(WR, 1, WR, 0, 0, BH - 1, 0, 1);
         run(RD, 0, PRE, 0, 1, RD_PRE, 0, 0);
         run(RD, 0, PRE, 1, 1, RD_PRE - 1, 1, 0);
         run(WR, 0, PRE, 1, 1, WR_PRE, 0, 0);
         run(WR, 0, PRE, 0, 1, WR_PRE - 1, 1, 0);
         run(RD, 1, ACT, 0, 1, RD_PRE + PB, 0, 0);
         run(RD, 1, ACT, 0, 1, RD_PRE + PB - 1, 1, 0);
         run(WR, 1, ACT, 0, 1, WR_PRE + PB, 0, 0);
         run(WR, 1, ACT, 0, 1, WR_PRE + PB - 1, 1, 0);
         run(RD, 1, WR, 0, 1, RD_WR, 1, 0);
         run(WR, 1, RD, 0, 1, BH, 1, 1);
         run(PRE, 0, PRE, 1, 0, 1, 0, 0);
         run(RD, 0, ACT, 0, 1, BH, 1, 0);
         run(WR, 0, WR, 0, 0, BH, 0, 0);
      end
      wrap_up();
   end
endmodule

// ==== test/ap_ctrl_model.sv ====
// Purpose: controller model sending one whole command per command clock period
// Assumes: pins change on the falling edge of clock_in
// Notes: the command clock stands still between frames
`timescale 1ns/1ps
module ap_ctrl_model (
   // clock and request
   input wire logic clock_in,
   input wire logic go_in,
   input wire ap_seq_pkg::cmd_s cmd_in,
   input wire logic [9:0] fill_in,
   // command pins
   output logic ck_out,
   output logic cs_n_out,
   output logic [9:0] ca_out,
   output logic busy_out
);
   logic [4:0] cnt = 5'h00;
   logic [9:0] r;
   logic [9:0] fl;
   logic [3:0] m;
   logic [3:0] v;
   initial begin
      ck_out = 1'b0;
      cs_n_out = 1'b1;
      ca_out = 10'h000;
      busy_out = 1'b0;
   end
   always @(negedge clock_in) begin
      if (!busy_out && go_in) begin
         {m, v} = 8'h00;
         case (cmd_in.kind)
            ap_seq_pkg::CMD_ACT: {m, v} = {ap_seq_pkg::OP_ACT_MASK, ap_seq_pkg::OP_ACT_VAL};
            ap_seq_pkg::CMD_RD: {m, v} = {ap_seq_pkg::OP_RD_MASK, ap_seq_pkg::OP_RD_VAL};
            ap_seq_pkg::CMD_WR: {m, v} = {ap_seq_pkg::OP_WR_MASK, ap_seq_pkg::OP_WR_VAL};
            ap_seq_pkg::CMD_PRE: {m, v} = {ap_seq_pkg::OP_PRE_MASK, ap_seq_pkg::OP_PRE_VAL};
            default: {m, v} = 8'h00;
         endcase
         r = fill_in;
         r[3:0] = (r[3:0] & ~m) | v;
         r[9:7] = cmd_in.bank;
         if (cmd_in.kind == ap_seq_pkg::CMD_PRE) begin
            r[ap_seq_pkg::CA_ALL_BANK_BIT] = cmd_in.all_bank_flag;
         end
         fl = {fill_in[4:0], fill_in[9:5]};
         fl[ap_seq_pkg::CA_AUTO_CLOSE_BIT] = cmd_in.auto_close_flag;
         ck_out <= 1'b1;
         cs_n_out <= (cmd_in.kind == ap_seq_pkg::CMD_NONE);
         ca_out <= r;
         busy_out <= 1'b1;
         cnt <= 5'h01;
      end else if (busy_out) begin
         cnt <= cnt + 5'h01;
         if (cnt == 5'h08) begin
            ck_out <= 1'b0;
            ca_out <= fl;
         end
         // frames always run whole, never cut short
         if (cnt == 5'h0f) begin
            cs_n_out <= 1'b1;
            ca_out <= ~ca_out;
            busy_out <= 1'b0;
         end
      end
   end
endmodule

// ==== test/ap_seq_sva.sv ====
// Purpose: port checker for the bank precharge sequencer
// Assumes: command pin edges stand far apart against clock_in
// Notes: every change of bank open, error or auto close start status must follow a command pin edge closely
`timescale 1ns/1ps
module ap_seq_sva (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // command pins
   input wire logic ck_in,
   input wire logic cs_n_in,
   input wire logic [9:0] ca_in,
   // status
   input wire logic [ap_seq_pkg::NUM_BANKS-1:0] bank_open_out,
   input wire logic [ap_seq_pkg::NUM_BANKS-1:0] bank_precharging_out,
   input wire logic [ap_seq_pkg::NUM_BANKS-1:0] ap_start_out,
   input wire logic bank_error_out,
   input wire logic spacing_error_out
);
   logic ck_q;
   logic [7:0] since;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // age of the last pin edge; the sync chain must stay well inside a half period
   always_ff @(posedge clock_in) begin
      ck_q <= ck_in;
      if (rst_in) begin
         since <= 8'hff;
      end else if (ck_in != ck_q) begin
         since <= 8'h00;
      end else if (since != 8'hff) begin
         since <= since + 8'h01;
      end
   end
   AST_AP_PULSE: assert property (|ap_start_out |=> ~|(ap_start_out & $past(ap_start_out)))
      else $error("auto close start longer than one cycle");
   AST_OPEN_EXCL: assert property ((bank_open_out & bank_precharging_out) == '0)
      else $error("bank open and precharging at once");
   AST_ERR_PULSE: assert property (bank_error_out |=> !bank_error_out)
      else $error("bank error longer than one cycle");
   AST_SPC_PULSE: assert property (spacing_error_out |=> !spacing_error_out)
      else $error("spacing error longer than one cycle");
   AST_OPEN_SYNC: assert property (!$stable(bank_open_out) |-> since <= 8'h07)
      else $error("bank state moved without a command clock edge");
   AST_ERR_SYNC: assert property (bank_error_out || spacing_error_out |-> since <= 8'h07)
      else $error("error flagged away from a command clock edge");
   AST_AP_SYNC: assert property (|ap_start_out |-> since <= 8'h07)
      else $error("auto close began away from a rising edge");
   for (genvar i = 0; i < ap_seq_pkg::NUM_BANKS; i++) begin : g_bank
      sequence s_closing;
         ##[0:1] (bank_precharging_out[i] && !bank_open_out[i]) [*4];
      endsequence
      AST_AP_CLOSE: assert property (ap_start_out[i] |->
         $past(bank_open_out[i], 2) ##0 s_closing)
         else $error("auto close did not close an open bank");
      AST_FALL_PRE: assert property ($fell(bank_open_out[i]) |-> bank_precharging_out[i])
         else $error("closed bank skipped its precharge period");
   end
endmodule
bind ap_bank_sequencer ap_seq_sva u_sva (.clock_in(clock_in), .rst_in(rst_in), .ck_in(ck_in),
   .cs_n_in(cs_n_in), .ca_in(ca_in), .bank_open_out(bank_open_out),
   .bank_precharging_out(bank_precharging_out), .ap_start_out(ap_start_out),
   .bank_error_out(bank_error_out), .spacing_error_out(spacing_error_out));
